// File: design/sadc_ctrl.sv
// successive-approximation converter control with temperature indicator control
`timescale 1ns/100ps
`default_nettype none
`include "sadc_defines.svh"
module sadc_ctrl
  import sadc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        cmp_in,
  input  wire logic        frc_clk_in,
  input  wire logic        sleep_in,
  output sadc_analog_t     analog,
  output logic             wake_req,
  output logic             isr_req
);

  // --------------------------------------------------------------
  // registers and state
  // --------------------------------------------------------------
  logic [7:0]  ctrl0_reg;
  logic [7:0]  ctrl1_reg;
  logic [7:0]  fvr_reg;
  logic        flag_reg;
  logic        ie_reg;
  logic [1:0]  intctl_reg;
  logic [9:0]  res_reg;
  logic        off_reg;
  sadc_state_t st_reg;
  logic [4:0]  hcnt_reg;
  logic [9:0]  sar_reg;
  logic [3:0]  ndone_reg;
  logic        last_reg;
  logic        cmp_s1, cmp_s2;
  logic        frc_s1, frc_s2, frc_s3;
  logic        wr_pend_reg, rd_pend_reg;
  logic [7:0]  addr_reg;
  logic        half_tick;

  logic [2:0]  cs;
  logic        is_frc;
  logic        wr_now, rd_take;
  logic        sw_go_set, sw_go_clr, start, done, decide, sleep_abort;
  logic        go_keep;
  logic [15:0] res_just;

  assign cs     = ctrl1_reg[`SADC_C1_CS_LO +: 3];
  assign is_frc = sadc_is_frc(cs);

  // fill undecided bits with the last decided bit
  function automatic logic [9:0] sadc_fill(input logic [9:0] sar, input logic [3:0] n,
                                           input logic last);
    logic [9:0] r;
    r = sar;
    for (int b = 0; b < 10; b++) begin
      if (4'(9 - b) >= n) r[b] = last;
    end
    return r;
  endfunction

  // justified byte pair of the result, high byte on top
  function automatic logic [15:0] sadc_just(input logic [9:0] r, input logic right);
    if (right) return {6'h00, r};
    else       return {r, 6'h00};
  endfunction

  // result byte pair in the selected justification
  assign res_just = sadc_just(res_reg, ctrl1_reg[`SADC_C1_FM]);

  // --------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------
  // comparator and rc clock come from outside the hclk domain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      frc_s1 <= 1'b0;
      frc_s2 <= 1'b0;
      frc_s3 <= 1'b0;
    end else if (ce) begin
      cmp_s1 <= cmp_in;
      cmp_s2 <= cmp_s1;
      frc_s1 <= frc_clk_in;
      frc_s2 <= frc_s1;
      frc_s3 <= frc_s2;
    end
  end

  // conversion clock: divided hclk or rc edges
  sadc_tad_gen #(.DIV_W(6)) u_tad (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .run       (st_reg == SADC_CONV),
    .frc_edge  (frc_s2 ^ frc_s3),
    .sel       (cs),
    .half_tick (half_tick)
  );

  // --------------------------------------------------------------
  // bus slave
  // --------------------------------------------------------------
  assign wr_now  = wr_pend_reg;
  assign rd_take = rd_pend_reg;

  // writes take no wait; reads wait one cycle so a preceding write is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else if (ce) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hreadyout   <= 1'b1;
      if (hready && hsel && htrans[1]) begin
        addr_reg    <= haddr[7:0];
        wr_pend_reg <= hwrite;
        rd_pend_reg <= !hwrite;
        hreadyout   <= hwrite;
      end
    end
  end

  // read data, unmapped offsets read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && rd_take) begin
      if (addr_reg == `SADC_OFF_CTRL0) begin
        hrdata <= {24'h000000, ctrl0_reg};
      end else if (addr_reg == `SADC_OFF_CTRL1) begin
        hrdata <= {24'h000000, ctrl1_reg};
      end else if (addr_reg == `SADC_OFF_RES_HIGH) begin
        hrdata <= {24'h000000, res_just[15:8]};
      end else if (addr_reg == `SADC_OFF_RES_LOW) begin
        hrdata <= {24'h000000, res_just[7:0]};
      end else if (addr_reg == `SADC_OFF_FVR) begin
        hrdata <= {24'h000000, fvr_reg};
      end else if (addr_reg == `SADC_OFF_PFLAG) begin
        hrdata <= {31'h00000000, flag_reg};
      end else if (addr_reg == `SADC_OFF_PENABLE) begin
        hrdata <= {31'h00000000, ie_reg};
      end else if (addr_reg == `SADC_OFF_INTCTL) begin
        hrdata <= {30'h00000000, intctl_reg};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // --------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------
  assign sw_go_set = wr_now && addr_reg == `SADC_OFF_CTRL0 && hwdata[`SADC_C0_GO];
  assign sw_go_clr = wr_now && addr_reg == `SADC_OFF_CTRL0 && !hwdata[`SADC_C0_GO];
  // a start needs the converter already on before this write
  assign start = sw_go_set && st_reg == SADC_IDLE && ctrl0_reg[`SADC_C0_ON]
               && hwdata[`SADC_C0_ON] && !off_reg;
  assign decide = st_reg == SADC_CONV && half_tick && hcnt_reg[0]
               && hcnt_reg >= `SADC_HALF_FIRST_D;
  assign done = st_reg == SADC_CONV && half_tick && hcnt_reg == `SADC_HALF_LAST;
  assign sleep_abort = sleep_in && !is_frc && st_reg == SADC_CONV;
  // a go write during a running conversion keeps the in-progress bit up
  assign go_keep = sw_go_set && st_reg == SADC_CONV && !done && !sleep_abort;

  // control registers; go is cleared by hardware at completion or abort
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl0_reg  <= `SADC_RST_BYTE;
      ctrl1_reg  <= `SADC_RST_BYTE;
      fvr_reg    <= `SADC_RST_BYTE;
      ie_reg     <= 1'b0;
      intctl_reg <= 2'b00;
    end else if (ce) begin
      if (wr_now && addr_reg == `SADC_OFF_CTRL0) begin
        ctrl0_reg <= {1'b0, hwdata[6:2], start || go_keep, hwdata[`SADC_C0_ON]};
      end else if (done || sleep_abort) begin
        ctrl0_reg[`SADC_C0_GO] <= 1'b0;
      end
      if (wr_now && addr_reg == `SADC_OFF_CTRL1) begin
        ctrl1_reg <= {hwdata[7:4], 2'b00, hwdata[1:0]};
      end
      if (wr_now && addr_reg == `SADC_OFF_FVR) begin
        fvr_reg <= {hwdata[7], 1'b0, hwdata[5:0]};
      end
      if (wr_now && addr_reg == `SADC_OFF_PENABLE) begin
        ie_reg <= hwdata[`SADC_PE_IE];
      end
      if (wr_now && addr_reg == `SADC_OFF_INTCTL) begin
        intctl_reg <= hwdata[1:0];
      end
    end
  end

  // done flag: set on every completion, cleared only by software, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_reg <= 1'b0;
    end else if (ce) begin
      if (done) begin
        flag_reg <= 1'b1;
      end else if (wr_now && addr_reg == `SADC_OFF_PFLAG) begin
        flag_reg <= hwdata[`SADC_PF_DONE];
      end
    end
  end

  // --------------------------------------------------------------
  // successive approximation sequence
  // --------------------------------------------------------------
  // one hold period, ten decisions, then a final half period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg    <= SADC_IDLE;
      hcnt_reg  <= 5'd0;
      sar_reg   <= 10'h000;
      ndone_reg <= 4'd0;
      last_reg  <= 1'b0;
      res_reg   <= 10'h000;
    end else if (ce) begin
      case (st_reg)
        SADC_IDLE: begin
          if (start) begin
            st_reg    <= SADC_CONV;
            hcnt_reg  <= 5'd0;
            sar_reg   <= 10'h200;
            ndone_reg <= 4'd0;
            last_reg  <= 1'b0;
          end
        end
        SADC_CONV: begin
          if (sleep_abort) begin
            st_reg <= SADC_IDLE;
          end else if (sw_go_clr) begin
            st_reg  <= SADC_IDLE;
            res_reg <= sadc_fill(sar_reg, ndone_reg, last_reg);
          end else if (done) begin
            st_reg  <= SADC_IDLE;
            res_reg <= sar_reg;
          end else if (half_tick) begin
            hcnt_reg <= hcnt_reg + 5'd1;
            if (decide) begin
              sar_reg[4'd9 - ndone_reg] <= cmp_s2;
              if (ndone_reg != 4'd9) begin
                sar_reg[4'd8 - ndone_reg] <= 1'b1;
              end
              ndone_reg <= ndone_reg + 4'd1;
              last_reg  <= cmp_s2;
            end
          end
        end
        default: st_reg <= SADC_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // sleep power-down, wake and vector requests
  // --------------------------------------------------------------
  // off during sleep with divided clock, or after an unannounced sleep conversion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      off_reg  <= 1'b0;
      wake_req <= 1'b0;
      isr_req  <= 1'b0;
    end else if (ce) begin
      if (!sleep_in) begin
        off_reg <= 1'b0;
      end else if (!is_frc || (done && !ie_reg)) begin
        off_reg <= 1'b1;
      end
      wake_req <= sleep_in && flag_reg && ie_reg && intctl_reg[`SADC_IC_PERIPHERAL_IRQ_ENABLE];
      isr_req  <= flag_reg && ie_reg && intctl_reg[`SADC_IC_PERIPHERAL_IRQ_ENABLE]
                  && intctl_reg[`SADC_IC_GIE];
    end
  end

  // --------------------------------------------------------------
  // analog control outputs
  // --------------------------------------------------------------
  // one shared sample-and-hold tracks while idle and holds while converting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog <= '0;
    end else if (ce) begin
      analog.powered   <= ctrl0_reg[`SADC_C0_ON] && !off_reg && !sleep_abort;
      analog.sample    <= st_reg == SADC_IDLE && !start;
      analog.channel   <= ctrl0_reg[6:2];
      analog.src_valid <= ctrl0_reg[6:4] == 3'b000
                          || ctrl0_reg[6:2] == `SADC_CH_TEMP
                          || ctrl0_reg[6:2] == `SADC_CH_DAC
                          || ctrl0_reg[6:2] == `SADC_CH_FVR;
      analog.pref      <= ctrl1_reg[`SADC_C1_PREF_LO +: 2];
      analog.temp_sensor_enable      <= fvr_reg[`SADC_FVR_TEMP_SENSOR_ENABLE];
      analog.temp_range_select     <= fvr_reg[`SADC_FVR_TEMP_RANGE_SELECT];
      analog.fixed_reference_enable     <= fvr_reg[`SADC_FVR_EN];
      analog.cd_gain   <= fvr_reg[`SADC_FVR_CDGAIN_LO +: 2];
      analog.ad_gain   <= fvr_reg[`SADC_FVR_ADGAIN_LO +: 2];
      analog.trial     <= sar_reg;
    end
  end

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_temp_sensor_enable_power: assert property (ce && !fvr_reg[`SADC_FVR_TEMP_SENSOR_ENABLE] |=> !analog.temp_sensor_enable)
    else $error("temp circuit powered while disabled");
  a_range_follow: assert property (ce |=> analog.temp_range_select == $past(fvr_reg[`SADC_FVR_TEMP_RANGE_SELECT]))
    else $error("range output differs from range bit");
  a_conv_bound: assert property (st_reg == SADC_CONV |-> hcnt_reg <= `SADC_HALF_LAST)
    else $error("conversion ran past eleven and a half periods");
  a_done_effects: assert property (ce && done |=> flag_reg && !ctrl0_reg[`SADC_C0_GO]
                                   && st_reg == SADC_IDLE)
    else $error("completion did not clear go and set flag");
  a_sleep_abort: assert property (ce && sleep_abort ##1 ce |=> !analog.powered
                                  && ctrl0_reg[`SADC_C0_ON])
    else $error("sleep with divided clock did not power off");
  a_wake_gate: assert property (ce && wake_req |-> $past(flag_reg) && $past(ie_reg))
    else $error("wake without done flag and enable");
  a_isr_gate: assert property (ce && isr_req |-> $past(intctl_reg[`SADC_IC_GIE]))
    else $error("vector request without global enable");
  a_partial_fill: assert property (ce && st_reg == SADC_CONV && sw_go_clr && !sleep_abort
                                   |=> res_reg == sadc_fill($past(sar_reg), $past(ndone_reg),
                                                            $past(last_reg)))
    else $error("aborted result not filled with last bit");
  a_chan_valid: assert property (analog.src_valid |-> analog.channel <= 5'h03
                                 || analog.channel >= `SADC_CH_TEMP)
    else $error("invalid channel marked as a source");

endmodule // sadc_ctrl
`default_nettype wire

// File: design/sadc_tad_gen.sv
// half bit-conversion period tick generator
`timescale 1ns/100ps
`default_nettype none
module sadc_tad_gen
  import sadc_pkg::*;
#(
  parameter int DIV_W = 6
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic       frc_edge,
  input  wire logic [2:0] sel,
  output logic            half_tick
);

  // refuse counter widths too small for the slowest divided clock
  if (DIV_W < 6) begin : g_div_w_check
    $error("sadc_tad_gen: DIV_W must be at least 6");
  end

  logic [DIV_W-1:0] cnt_reg;

  // divided hclk follows any change of hclk; rc option ticks on every rc edge with the counter held at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg   <= '0;
      half_tick <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt_reg   <= '0;
        half_tick <= 1'b0;
      end else if (sadc_is_frc(sel)) begin
        cnt_reg   <= '0;
        half_tick <= frc_edge;
      end else if (cnt_reg >= DIV_W'(sadc_half_lim(sel))) begin
        cnt_reg   <= '0;
        half_tick <= 1'b1;
      end else begin
        cnt_reg   <= cnt_reg + DIV_W'(1);
        half_tick <= 1'b0;
      end
    end
  end

endmodule // sadc_tad_gen
`default_nettype wire

// File: dv/tb.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sadc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic         hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp;
  logic         cmp_in, frc_clk_in, sleep_in, frc_run, wake_req, isr_req;
  logic [31:0]  haddr, hwdata, hrdata;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [9:0]   tgt, q;
  sadc_analog_t analog;
  int           n_mismatch, samples_checked, n;
  logic [4:0]   channel_select_field [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1d, 5'h1e, 5'h1f, 5'h05};
  logic [2:0]   css [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};

  sadc_ctrl uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cmp_in(cmp_in),
    .frc_clk_in(frc_clk_in), .sleep_in(sleep_in), .analog(analog), .wake_req(wake_req),
    .isr_req(isr_req));

  // system clock and an rc clock that only runs while asked
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    frc_clk_in = 1'b0;
    forever #30 if (frc_run) frc_clk_in = ~frc_clk_in;
  end
  // comparator stand-in: input level tgt against the trial code
  always @(posedge hclk) cmp_in <= (analog.trial <= tgt);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wait_ready;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 20);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: bus wait ran out", $time);
      summarize();
    end
  endtask

  // one single word transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wait_ready();
    q = hrdata[9:0];
    if (hresp !== 1'b0) begin
      n_mismatch++;
      $display("unexpected at %0t: error response on the bus", $time);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [9:0] e);
    xfer(1'b0, a, 8'h00);
    chk(q, e);
  endtask

  // length of one whole conversion (sample low) in hclk cycles
  task automatic conv_len(output int len);
    int i;
    len = 0;
    i = 0;
    while (analog.sample !== 1'b0 && i < 8) begin
      @(posedge hclk);
      i++;
    end
    while (analog.sample === 1'b0 && len < 2000) begin
      @(posedge hclk);
      len++;
    end
    if (i >= 8 || len >= 2000) begin
      n_mismatch++;
      $display("unexpected at %0t: conversion wait ran out", $time);
      summarize();
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    hresetn = 1'b0; ce = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = '0; cmp_in = 1'b0; sleep_in = 1'b0; frc_run = 1'b0;
    tgt = '0; n_mismatch = 0; samples_checked = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int a = 0; a <= 32; a += 4) rd(8'(a), 10'h000);
    // temperature indicator enable and range
    wr(8'h10, 8'hff);
    rd(8'h10, 10'h0bf);
    chk({9'h0, analog.temp_sensor_enable}, 10'h1);
    chk({9'h0, analog.temp_range_select}, 10'h1);
    chk({5'h0, analog.fixed_reference_enable, analog.cd_gain, analog.ad_gain}, 10'h01f);
    wr(8'h10, 8'h20);
    repeat (2) @(posedge hclk);
    chk({9'h0, analog.temp_range_select}, 10'h0);
    wr(8'h10, 8'h00);
    repeat (2) @(posedge hclk);
    chk({9'h0, analog.temp_sensor_enable}, 10'h0);
    // every source code plus one unused code
    for (int k = 0; k < 8; k++) begin
      wr(8'h00, {1'b0, channel_select_field[k], 2'b00});
      repeat (2) @(posedge hclk);
      chk({5'h0, analog.channel}, {5'h0, channel_select_field[k]});
      chk({9'h0, analog.src_valid}, {9'h0, k < 7});
    end
    wr(8'h04, 8'h02);
    repeat (2) @(posedge hclk);
    chk({8'h0, analog.pref}, 10'h002);
    wr(8'h00, 8'h03);
    rd(8'h00, 10'h001);
    repeat (200) @(posedge hclk);
    // every divided clock ratio: conversion length scales with ratio
    tgt = 10'h3ff;
    for (int k = 0; k < 6; k++) begin
      wr(8'h04, {1'b1, css[k], 4'h0});
      wr(8'h00, 8'h01);
      wr(8'h00, 8'h03);
      conv_len(n);
      chk({9'h0, n >= 22 * (1 << k) - 2 && n <= 24 * (1 << k) + 4}, 10'h1);
      rd(8'h00, 10'h001);
      rd(8'h08, 10'h003);
      rd(8'h0c, 10'h0ff);
      rd(8'h14, 10'h001);
      wr(8'h14, 8'h00);
    end
    // result value in both justifications
    tgt = 10'h2a5;
    wr(8'h04, 8'h90);
    wr(8'h00, 8'h03);
    conv_len(n);
    rd(8'h08, 10'h002);
    rd(8'h0c, 10'h0a5);
    wr(8'h04, 8'h10);
    rd(8'h08, 10'h0a9);
    rd(8'h0c, 10'h040);
    // flag stays until software clears it; interrupt gating
    repeat (20) @(posedge hclk);
    rd(8'h14, 10'h001);
    wr(8'h18, 8'h01);
    wr(8'h1c, 8'h03);
    repeat (3) @(posedge hclk);
    chk({9'h0, isr_req}, 10'h1);
    wr(8'h1c, 8'h01);
    repeat (3) @(posedge hclk);
    chk({9'h0, isr_req}, 10'h0);
    sleep_in <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({9'h0, wake_req}, 10'h1);
    sleep_in <= 1'b0;
    wr(8'h14, 8'h00);
    rd(8'h14, 10'h000);
    // early stop after two decided bits
    wr(8'h04, 8'he0);
    wr(8'h00, 8'h03);
    repeat (205) @(posedge hclk);
    wr(8'h00, 8'h01);
    rd(8'h08, 10'h002);
    rd(8'h0c, 10'h000);
    rd(8'h14, 10'h000);
    // sleep with a divided clock aborts and powers down
    wr(8'h04, 8'h90);
    wr(8'h00, 8'h03);
    repeat (20) @(posedge hclk);
    sleep_in <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({9'h0, analog.powered}, 10'h0);
    rd(8'h00, 10'h001);
    repeat (300) @(posedge hclk);
    rd(8'h14, 10'h000);
    sleep_in <= 1'b0;
    repeat (3) @(posedge hclk);
    chk({9'h0, analog.powered}, 10'h1);
    // rc clock conversion completes in sleep and wakes in line
    wr(8'h04, 8'hb0);
    tgt = 10'h155;
    wr(8'h00, 8'h03);
    sleep_in <= 1'b1;
    frc_run <= 1'b1;
    n = 0;
    while (wake_req !== 1'b1 && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    chk({9'h0, wake_req}, 10'h1);
    if (n >= 3000) summarize();
    chk({9'h0, isr_req}, 10'h0);
    frc_run <= 1'b0;
    sleep_in <= 1'b0;
    rd(8'h08, 10'h001);
    rd(8'h0c, 10'h055);
    // temperature channel: settle after selection, space repeated conversions
    wr(8'h04, 8'h90);
    tgt = 10'h1c3;
    wr(8'h00, 8'h75);
    repeat (20000) @(posedge hclk);
    wr(8'h00, 8'h77);
    conv_len(n);
    rd(8'h00, 10'h075);
    rd(8'h08, 10'h001);
    rd(8'h0c, 10'h0c3);
    repeat (20000) @(posedge hclk);
    wr(8'h00, 8'h77);
    conv_len(n);
    chk({9'h0, n >= 86 && n <= 100}, 10'h1);
    rd(8'h0c, 10'h0c3);
    summarize();
  end
endmodule // tb
`default_nettype wire

// File: shared/sadc_defines.svh
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH

// byte offsets on the bus
`define SADC_OFF_CTRL0     8'h00
`define SADC_OFF_CTRL1     8'h04
`define SADC_OFF_RES_HIGH  8'h08
`define SADC_OFF_RES_LOW   8'h0c
`define SADC_OFF_FVR       8'h10
`define SADC_OFF_PFLAG     8'h14
`define SADC_OFF_PENABLE   8'h18
`define SADC_OFF_INTCTL    8'h1c

// converter_control_zero fields
`define SADC_C0_ON         0
`define SADC_C0_GO         1
`define SADC_C0_CHS_LO     2
// converter_control_one fields
`define SADC_C1_PREF_LO    0
`define SADC_C1_CS_LO      4
`define SADC_C1_FM         7
// fixed_reference_and_temp_control fields
`define SADC_FVR_ADGAIN_LO 0
`define SADC_FVR_CDGAIN_LO 2
`define SADC_FVR_TEMP_RANGE_SELECT     4
`define SADC_FVR_TEMP_SENSOR_ENABLE      5
`define SADC_FVR_RDY       6
`define SADC_FVR_EN        7
// flag, enable and interrupt control bits
`define SADC_PF_DONE       0
`define SADC_PE_IE         0
`define SADC_IC_PERIPHERAL_IRQ_ENABLE       0
`define SADC_IC_GIE        1

// reset values
`define SADC_RST_BYTE      8'h00

// channel codes of the internal sources
`define SADC_CH_TEMP       5'h1d
`define SADC_CH_DAC        5'h1e
`define SADC_CH_FVR        5'h1f

// conversion timing in half bit-conversion periods: 11.5 periods
`define SADC_HALF_LAST     5'd22
`define SADC_HALF_FIRST_D  5'd3

`endif

// File: shared/sadc_pkg.sv
// types and shared decode functions of the converter control
package sadc_pkg;

  typedef enum logic {
    SADC_IDLE,
    SADC_CONV
  } sadc_state_t;

  // control bundle towards the analog macro
  typedef struct packed {
    logic       powered;
    logic       sample;
    logic       src_valid;
    logic [4:0] channel;
    logic [1:0] pref;
    logic       temp_sensor_enable;
    logic       temp_range_select;
    logic       fixed_reference_enable;
    logic [1:0] cd_gain;
    logic [1:0] ad_gain;
    logic [9:0] trial;
  } sadc_analog_t;

  // clock select codes x11 pick the internal rc clock
  function automatic logic sadc_is_frc(input logic [2:0] sel);
    return sel[1:0] == 2'b11;
  endfunction

  // hclk cycles per half period minus one: ratio 2^(2*sel[1:0]+sel[2]+1)
  function automatic logic [5:0] sadc_half_lim(input logic [2:0] sel);
    logic [2:0] e;
    e = {sel[1:0], 1'b0} + {2'b00, sel[2]};
    return (6'h01 << e) - 6'h01;
  endfunction

endpackage
